//--- design/ppw_drop.sv
`timescale 1ns/1ps
`default_nettype none
module ppw_drop import ppw_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Settings
    input wire logic enable,
    input wire logic drop_all,
    input wire logic drop_srp,
    input wire logic [10:0] min_thr,
    input wire logic [10:0] max_thr,
    input wire logic [10:0] prob_scale,
    // Packet
    input wire logic pkt_hit,
    input wire logic is_srp,
    input wire logic [1:0] color,
    input wire logic [10:0] pm_level,
    output logic drop
);
    logic [15:0] lfsr_q;
    wire logic over_max = pm_level > max_thr;
    wire logic over_min = pm_level > min_thr;
    wire logic prob_hit = lfsr_q[10:0] < prob_scale;
    wire logic drop_raw = over_max ? (drop_all || prob_hit)
        : (over_min && color != COLOR_GREEN && prob_hit);

    assign drop = enable && pkt_hit && drop_raw && (drop_srp || !is_srp);

    // Free-running so decisions do not repeat with traffic pattern
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lfsr_q <= 16'hACE1;
        end else begin
            lfsr_q <= {lfsr_q[14:0],
                lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        end
    end
endmodule : ppw_drop
`default_nettype wire

//--- design/ppw_meter.sv
`timescale 1ns/1ps
`default_nettype none
module ppw_meter import ppw_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Bucket parameters
    input wire logic [15:0] committed_rate,
    input wire logic [15:0] peak_rate,
    input wire logic [15:0] committed_burst,
    input wire logic [15:0] peak_burst,
    // Packet
    input wire logic refill,
    input wire logic pkt_hit,
    input wire logic color_aware,
    input wire logic [1:0] in_color,
    input wire logic [15:0] pkt_len,
    output logic [1:0] color
);
    logic [15:0] cb_q, pb_q, cb_d, pb_d, cb_left, pb_left;
    logic [16:0] c_sum, p_sum;
    wire logic c_ok = cb_q >= pkt_len;
    wire logic p_ok = pb_q >= pkt_len;

    // Two-rate meter; an aware red or yellow can only stay or darken
    assign color = (!p_ok || (color_aware && in_color == COLOR_RED))
        ? COLOR_RED
        : (!c_ok || (color_aware && in_color == COLOR_YELLOW))
        ? COLOR_YELLOW : COLOR_GREEN;

    assign cb_left = cb_q - ((pkt_hit && color == COLOR_GREEN)
        ? pkt_len : 16'h0000);
    assign pb_left = pb_q - ((pkt_hit && color != COLOR_RED)
        ? pkt_len : 16'h0000);
    assign c_sum = {1'b0, cb_left}
        + {1'b0, refill ? committed_rate : 16'h0000};
    assign p_sum = {1'b0, pb_left} + {1'b0, refill ? peak_rate : 16'h0000};
    // Clamp also trims a bucket when software shrinks the burst size
    assign cb_d = (c_sum > {1'b0, committed_burst}) ? committed_burst
        : c_sum[15:0];
    assign pb_d = (p_sum > {1'b0, peak_burst}) ? peak_burst : p_sum[15:0];

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cb_q <= 16'h0000;
            pb_q <= 16'h0000;
        end else begin
            cb_q <= cb_d;
            pb_q <= pb_d;
        end
    end
endmodule : ppw_meter
`default_nettype wire

//--- design/ppw_top.sv
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// (RULE1) Enable bit 0 turns policing and early drop on; clear disables both.
// (RULE2) Bit 1 set meters color-blind, clear meters color-aware.
// (RULE3) Reservation-protocol packets are dropped only while bit 2 is set.
// (RULE4) Bit 3 in aware mode swaps the DSCP color for the remapped one.
// (RULE5) Bit 4 enables writing the policing color into forwarded DSCP.
// (RULE6) Bits 6:5 give the non-IP frame color, reset value 01.
// (RULE7) Bit 7 set: per-port per-queue policing; clear: per queue only.
// (RULE8) Per-queue-only policing uses the port index 0 rates.
// (RULE9) Bits 9:8 pick monitored kind: 11 red, 10 yellow, 01 green, 00 drop.
// (RULE10) Bit 10 drops everything above the memory maximum threshold.
// (RULE11) Bit 11 makes color counts include only dropped packets.
// (RULE12) Rate bits 31:16 hold the indexed committed rate, reset 0x1000.
// (RULE13) Rate bits 15:0 hold the indexed peak rate, reset 0x2000.
// (RULE14) Burst bits 31:16 hold committed burst bytes, reset 0x1000.
// (RULE15) Burst bits 15:0 hold peak burst bytes, reset 0x3000.
// (RULE16) Bits 26:16 hold memory maximum threshold, reset 0x400.
// (RULE17) Bits 10:0 hold memory minimum threshold, reset 0x080.
// (RULE18) Pointer bits 18:16 choose the port of the indirect entry.
// (RULE19) Pointer bits 1:0 choose one of four queues.
// (RULE20) Each flow is metered by committed and peak token buckets.
// (RULE21) Reserved bits read zero and ignore writes.
module ppw_top import ppw_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Packet classification request
    input wire logic [2:0] local_port,
    input wire logic pkt_valid,
    input wire logic [1:0] pkt_queue,
    input wire logic [15:0] pkt_len,
    input wire logic pkt_is_ip,
    input wire logic [1:0] pkt_dscp_color,
    input wire logic [1:0] pkt_remap_color,
    input wire logic pkt_is_srp,
    input wire logic [10:0] pm_level,
    input wire logic [10:0] memory_drop_probability_scale,
    // Packet result
    output logic res_valid,
    output logic [1:0] res_color,
    output logic res_drop,
    output logic res_mark_dscp,
    output logic mon_event,
    output logic police_active
);
    logic [31:0] ctl_q, ptr_q, pm_q, prdata_q;
    logic [31:0] rate_mem [ENTRIES];
    logic [31:0] burst_mem [ENTRIES];
    logic [15:0] refill_cnt_q;
    logic res_valid_q, res_drop_q, res_mark_q, mon_event_q;
    logic [1:0] res_color_q;
    logic [1:0] q_color [QUEUES];

    // Address decode
    wire logic setup = psel && !penable;
    wire logic access = psel && penable;
    wire logic hit_ptr = paddr == ADDR_POINTER;
    wire logic hit_ctl = paddr == ADDR_CONTROL;
    wire logic hit_rate = paddr == ADDR_RATE;
    wire logic hit_burst = paddr == ADDR_BURST;
    wire logic hit_pm = paddr == ADDR_PM_THRESH;
    wire logic hit_any = hit_ptr || hit_ctl || hit_rate || hit_burst
        || hit_pm;
    wire logic wr = access && pwrite && hit_any;
    wire logic [31:0] strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
        {8{pstrb[1]}}, {8{pstrb[0]}}};

    // Indirect index from pointer
    wire logic [2:0] ptr_port = ptr_q[PTR_PORT_LO +: 3]; // [RULE18]
    wire logic [1:0] ptr_queue = ptr_q[PTR_QUEUE_LO +: 2]; // [RULE19]
    wire logic [4:0] ptr_idx = {ptr_port, ptr_queue};

    // Control fields
    wire logic ctl_enable = ctl_q[CTL_ENABLE];
    wire logic ctl_blind = ctl_q[CTL_BLIND];
    wire logic ctl_drop_srp = ctl_q[CTL_DROP_SRP];
    wire logic ctl_remap = ctl_q[CTL_REMAP];
    wire logic ctl_mark = ctl_q[CTL_MARK];
    wire logic [1:0] non_ip_frame_color = ctl_q[CTL_NONIP_LO +: 2];
    wire logic ctl_port_based = ctl_q[CTL_PORT_BASED];
    wire logic [1:0] ctl_mon_sel = ctl_q[CTL_MON_LO +: 2];
    wire logic ctl_drop_all = ctl_q[CTL_DROP_ALL];
    wire logic ctl_dropped_only = ctl_q[CTL_DROPPED_ONLY];

    // Read mux; reserved bits are masked at write so read back as zero
    wire logic [31:0] rd_mux = hit_ptr ? ptr_q
        : hit_ctl ? ctl_q
        : hit_rate ? rate_mem[ptr_idx]
        : hit_burst ? burst_mem[ptr_idx]
        : hit_pm ? pm_q : 32'h0000_0000;

    function automatic logic [31:0] merge(input logic [31:0] old_val,
        input logic [31:0] new_val, input logic [31:0] keep);
        merge = (old_val & ~keep) | (new_val & keep);
    endfunction : merge

    // Read data is captured in setup so it leaves a flop with no wait
    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = access && !hit_any;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctl_q <= CTL_RESET; // [RULE6]
            ptr_q <= PTR_RESET;
            pm_q <= PM_RESET; // [RULE16] [RULE17]
        end else if (wr) begin
            if (hit_ctl) begin
                ctl_q <= merge(ctl_q, pwdata,
                    strb_mask & CTL_MASK); // [RULE21]
            end
            if (hit_ptr) begin
                ptr_q <= merge(ptr_q, pwdata,
                    strb_mask & PTR_MASK); // [RULE21]
            end
            if (hit_pm) begin
                pm_q <= merge(pm_q, pwdata, strb_mask & PM_MASK); // [RULE21]
            end
        end
    end

    // Indirect rate and burst entries, one per port and queue
    genvar gi;
    generate
        for (gi = 0; gi < ENTRIES; gi++) begin : g_entry
            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    rate_mem[gi] <= RATE_RESET; // [RULE12] [RULE13]
                    burst_mem[gi] <= BURST_RESET; // [RULE14] [RULE15]
                end else if (wr && ptr_idx == 5'(gi)) begin
                    if (hit_rate) begin
                        rate_mem[gi] <= merge(rate_mem[gi], pwdata,
                            strb_mask);
                    end
                    if (hit_burst) begin
                        burst_mem[gi] <= merge(burst_mem[gi], pwdata,
                            strb_mask);
                    end
                end
            end
        end
    endgenerate

    // Refill tick shared by all buckets
    wire logic refill = refill_cnt_q == REFILL_LAST;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            refill_cnt_q <= 16'h0000;
        end else begin
            refill_cnt_q <= refill ? 16'h0000 : refill_cnt_q + 16'h0001;
        end
    end

    // Shared policing reads the port 0 entries
    wire logic [2:0] pol_port = ctl_port_based // [RULE7] [RULE8]
        ? local_port : 3'h0;

    // Incoming color for aware metering
    wire logic [1:0] in_color = !pkt_is_ip ? non_ip_frame_color // [RULE6]
        : ctl_remap ? pkt_remap_color : pkt_dscp_color; // [RULE4]

    generate
        for (gi = 0; gi < QUEUES; gi++) begin : g_queue
            wire logic [4:0] idx = {pol_port, 2'(gi)};
            ppw_meter u_meter ( // [RULE20]
                .clk_sys(clk_sys),
                .reset(reset),
                .committed_rate(rate_mem[idx][31:16]),
                .peak_rate(rate_mem[idx][15:0]),
                .committed_burst(burst_mem[idx][31:16]),
                .peak_burst(burst_mem[idx][15:0]),
                .refill(refill),
                .pkt_hit(pkt_valid && ctl_enable && pkt_queue == 2'(gi)),
                .color_aware(!ctl_blind), // [RULE2]
                .in_color(in_color),
                .pkt_len(pkt_len),
                .color(q_color[gi])
            );
        end
    endgenerate

    // Disabled policing passes everything green
    wire logic [1:0] pol_color = ctl_enable ? q_color[pkt_queue]
        : COLOR_GREEN; // [RULE1]
    wire logic drop_now;

    ppw_drop u_drop (
        .clk_sys(clk_sys),
        .reset(reset),
        .enable(ctl_enable), // [RULE1]
        .drop_all(ctl_drop_all), // [RULE10]
        .drop_srp(ctl_drop_srp), // [RULE3]
        .min_thr(pm_q[10:0]),
        .max_thr(pm_q[26:16]),
        .prob_scale(memory_drop_probability_scale),
        .pkt_hit(pkt_valid),
        .is_srp(pkt_is_srp),
        .color(pol_color),
        .pm_level(pm_level),
        .drop(drop_now)
    );

    // Monitor only the flow chosen by the pointer
    wire logic mon_match = pkt_valid && local_port == ptr_port
        && pkt_queue == ptr_queue;
    wire logic mon_hit = (ctl_mon_sel == MON_DROPPED) ? drop_now // [RULE9]
        : (pol_color == ctl_mon_sel
        && (!ctl_dropped_only || drop_now)); // [RULE11]

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            res_valid_q <= 1'b0;
            res_color_q <= COLOR_GREEN;
            res_drop_q <= 1'b0;
            res_mark_q <= 1'b0;
            mon_event_q <= 1'b0;
        end else begin
            res_valid_q <= pkt_valid;
            res_color_q <= pkt_valid ? pol_color : res_color_q;
            res_drop_q <= drop_now;
            res_mark_q <= pkt_valid && ctl_enable && ctl_mark; // [RULE5]
            mon_event_q <= mon_match && mon_hit;
        end
    end

    assign res_valid = res_valid_q;
    assign res_color = res_color_q;
    assign res_drop = res_drop_q;
    assign res_mark_dscp = res_mark_q;
    assign mon_event = mon_event_q;
    assign police_active = ctl_enable;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence

    a_apb_ready: assert property (s_setup ##1 s_access |-> pready) // [RULE21]
        else $error("access phase without ready");
    sequence s_read_ctl;
        psel && !penable && !pwrite && hit_ctl;
    endsequence

    a_reserved_zero: assert property ( // [RULE21]
        s_read_ctl ##1 s_access |-> prdata[31:12] == 20'h00000)
        else $error("reserved control bits read nonzero");
    a_disabled_nodrop: assert property (pkt_valid && !ctl_enable // [RULE1]
        |=> !res_drop && res_color == COLOR_GREEN)
        else $error("drop or color while disabled");
    a_srp_exempt: assert property (pkt_valid && pkt_is_srp // [RULE3]
        && !ctl_drop_srp |=> !res_drop)
        else $error("reservation packet dropped");
    a_remap_red: assert property ( // [RULE4]
        pkt_valid && ctl_enable && !ctl_blind
        && pkt_is_ip && ctl_remap && pkt_remap_color == COLOR_RED
        |=> res_color == COLOR_RED)
        else $error("remapped red not kept");
    a_nonip_red: assert property ( // [RULE6]
        pkt_valid && ctl_enable && !ctl_blind
        && !pkt_is_ip && non_ip_frame_color == COLOR_RED
        |=> res_color == COLOR_RED)
        else $error("non-IP color not applied");
    a_mark_follows: assert property (pkt_valid // [RULE5]
        |=> res_mark_dscp == $past(ctl_enable && ctl_mark))
        else $error("mark flag wrong");
    a_drop_all: assert property ( // [RULE10]
        pkt_valid && ctl_enable && ctl_drop_all
        && pm_level > pm_q[26:16] && !pkt_is_srp |=> res_drop)
        else $error("drop-all not applied");
    a_mon_dropped: assert property ( // [RULE9]
        mon_match && ctl_mon_sel == MON_DROPPED
        |=> mon_event == res_drop)
        else $error("drop monitor mismatch");
    a_rate_write: assert property (wr && hit_rate && pstrb == 4'hF // [RULE12]
        |=> rate_mem[$past(ptr_idx)] == $past(pwdata))
        else $error("rate entry not written");
    a_pm_write: assert property (wr && hit_pm && pstrb == 4'hF // [RULE17]
        |=> pm_q == ($past(pwdata) & PM_MASK))
        else $error("threshold write wrong");
    a_ctl_write: assert property ( // [RULE21]
        wr && hit_ctl && pstrb == 4'hF
        |=> ctl_q == ($past(pwdata) & CTL_MASK))
        else $error("control write wrong");
    a_ptr_write: assert property ( // [RULE18]
        wr && hit_ptr && pstrb == 4'hF
        |=> ptr_q == ($past(pwdata) & PTR_MASK))
        else $error("pointer write wrong");
    a_burst_write: assert property ( // [RULE14]
        wr && hit_burst && pstrb == 4'hF
        |=> burst_mem[$past(ptr_idx)] == $past(pwdata))
        else $error("burst entry not written");
    a_unmapped_err: assert property ( // [RULE21]
        s_setup ##0 (!pwrite && !hit_any) ##1 s_access
        |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_dscp_red: assert property ( // [RULE4]
        pkt_valid && ctl_enable && !ctl_blind && pkt_is_ip
        && !ctl_remap && pkt_dscp_color == COLOR_RED
        |=> res_color == COLOR_RED)
        else $error("aware DSCP red not kept");
    a_nonip_yellow: assert property ( // [RULE6]
        pkt_valid && ctl_enable && !ctl_blind && !pkt_is_ip
        && non_ip_frame_color == COLOR_YELLOW
        |=> res_color != COLOR_GREEN)
        else $error("non-IP yellow promoted");
    a_green_kept: assert property ( // [RULE10]
        pkt_valid && pol_color == COLOR_GREEN
        && pm_level <= pm_q[26:16] |=> !res_drop)
        else $error("green dropped below maximum");
    a_mon_color: assert property ( // [RULE9]
        mon_match && ctl_mon_sel != MON_DROPPED && !ctl_dropped_only
        |=> mon_event == (res_color == $past(ctl_mon_sel)))
        else $error("color monitor mismatch");
    a_mon_dropcolor: assert property ( // [RULE11]
        mon_match && ctl_mon_sel != MON_DROPPED && ctl_dropped_only
        |=> mon_event == (res_drop && res_color == $past(ctl_mon_sel)))
        else $error("dropped color monitor mismatch");
    a_result_pulse: assert property ( // [RULE20]
        pkt_valid |=> res_valid)
        else $error("result missing");
endmodule : ppw_top
`default_nettype wire

//--- dv/port_policing_wred_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module port_policing_wred_config_tb import ppw_pkg::*;;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] local_port = 3'h0;
    logic pkt_valid = 1'b0;
    logic [1:0] pkt_queue = 2'h0;
    logic [15:0] pkt_len = 16'h0040;
    logic pkt_is_ip = 1'b0;
    logic [1:0] pkt_dscp_color = 2'h1;
    logic [1:0] pkt_remap_color = 2'h1;
    logic pkt_is_srp = 1'b0;
    logic [10:0] pm_level = 11'h000;
    logic [10:0] scale = 11'h000;
    logic res_valid;
    logic [1:0] res_color;
    logic res_drop;
    logic res_mark_dscp;
    logic mon_event;
    logic police_active;
    int fail_count = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic er;
    localparam logic [10:0] LVL_HI = 11'h7FF;
    localparam logic [10:0] LVL_EQ = 11'h400;

    ppw_top ppw_top_i (.clk_sys(clk_sys), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .local_port(local_port), .pkt_valid(pkt_valid),
        .pkt_queue(pkt_queue), .pkt_len(pkt_len), .pkt_is_ip(pkt_is_ip),
        .pkt_dscp_color(pkt_dscp_color), .pkt_remap_color(pkt_remap_color),
        .pkt_is_srp(pkt_is_srp), .pm_level(pm_level),
        .memory_drop_probability_scale(scale), .res_valid(res_valid),
        .res_color(res_color), .res_drop(res_drop),
        .res_mark_dscp(res_mark_dscp), .mon_event(mon_event),
        .police_active(police_active));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer; the request stands until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d, input logic [3:0] s,
            output logic [31:0] r, output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees ready
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        chk("pready", 32'h1, {31'h0, pready});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, 4'hF, r, e);
    endtask : wr

    task automatic rdchk(input string what, input logic [11:0] a,
            input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, 4'hF, r, e);
        chk(what, exp, r);
        chk({what, " err"}, 32'h0, {31'h0, e});
    endtask : rdchk

    // Sends one packet and checks the result in the following cycle
    task automatic pkt(input logic ip, input logic [1:0] dc,
            input logic [1:0] rc, input logic srp, input logic [10:0] lvl,
            input logic [1:0] ec, input logic ed, input logic em,
            input logic ev);
        @(posedge clk_sys);
        pkt_valid <= 1'b1;
        pkt_is_ip <= ip;
        pkt_dscp_color <= dc;
        pkt_remap_color <= rc;
        pkt_is_srp <= srp;
        pm_level <= lvl;
        @(posedge clk_sys);
        pkt_valid <= 1'b0;
        #1;
        chk("res_valid", 32'h1, {31'h0, res_valid});
        chk("res_color", {30'h0, ec}, {30'h0, res_color});
        chk("res_drop", {31'h0, ed}, {31'h0, res_drop});
        chk("res_mark_dscp", {31'h0, em}, {31'h0, res_mark_dscp});
        chk("mon_event", {31'h0, ev}, {31'h0, mon_event});
    endtask : pkt

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    initial begin
        #200000;
        fail_count++;
        test_done();
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        rdchk("control", ADDR_CONTROL, 32'h0000_0020);
        rdchk("pointer", ADDR_POINTER, 32'h0000_0000);
        rdchk("rate", ADDR_RATE, 32'h1000_2000);
        rdchk("burst", ADDR_BURST, 32'h1000_3000);
        rdchk("pm", ADDR_PM_THRESH, 32'h0400_0080);
        $display("test reset values done");
        // Buckets start empty; let several refills fill them
        repeat (3 * REFILL_CYCLES) @(posedge clk_sys);
        pkt(1'b1, 2'h3, 2'h3, 1'b0, LVL_HI, 2'h1, 1'b0, 1'b0, 1'b0);
        chk("police_active", 32'h0, {31'h0, police_active});
        wr(ADDR_CONTROL, 32'h0000_0013);
        #1;
        chk("police_active", 32'h1, {31'h0, police_active});
        pkt(1'b1, 2'h3, 2'h1, 1'b0, 11'h0, 2'h1, 1'b0, 1'b1, 1'b0);
        wr(ADDR_CONTROL, 32'h0000_0003);
        pkt(1'b1, 2'h3, 2'h1, 1'b0, 11'h0, 2'h1, 1'b0, 1'b0, 1'b0);
        $display("test enable and mark done");
        wr(ADDR_CONTROL, 32'h0000_0061);
        pkt(1'b0, 2'h1, 2'h1, 1'b0, 11'h0, 2'h3, 1'b0, 1'b0, 1'b0);
        wr(ADDR_CONTROL, 32'h0000_0041);
        pkt(1'b0, 2'h1, 2'h1, 1'b0, 11'h0, 2'h2, 1'b0, 1'b0, 1'b0);
        wr(ADDR_CONTROL, 32'h0000_0021);
        pkt(1'b0, 2'h3, 2'h3, 1'b0, 11'h0, 2'h1, 1'b0, 1'b0, 1'b0);
        pkt(1'b1, 2'h2, 2'h3, 1'b0, 11'h0, 2'h2, 1'b0, 1'b0, 1'b0);
        wr(ADDR_CONTROL, 32'h0000_0029);
        pkt(1'b1, 2'h2, 2'h3, 1'b0, 11'h0, 2'h3, 1'b0, 1'b0, 1'b0);
        pkt(1'b1, 2'h3, 2'h1, 1'b0, 11'h0, 2'h1, 1'b0, 1'b0, 1'b0);
        $display("test color aware done");
        wr(ADDR_CONTROL, 32'h0000_0403);
        pkt(1'b1, 2'h1, 2'h1, 1'b0, LVL_HI, 2'h1, 1'b1, 1'b0, 1'b1);
        pkt(1'b1, 2'h1, 2'h1, 1'b0, LVL_EQ, 2'h1, 1'b0, 1'b0, 1'b0);
        pkt(1'b1, 2'h1, 2'h1, 1'b1, LVL_HI, 2'h1, 1'b0, 1'b0, 1'b0);
        wr(ADDR_CONTROL, 32'h0000_0407);
        pkt(1'b1, 2'h1, 2'h1, 1'b1, LVL_HI, 2'h1, 1'b1, 1'b0, 1'b1);
        // Zero scale never wins the random draw above the maximum
        wr(ADDR_CONTROL, 32'h0000_0003);
        pkt(1'b1, 2'h1, 2'h1, 1'b0, LVL_HI, 2'h1, 1'b0, 1'b0, 1'b0);
        $display("test drop done");
        // Monitor watches port 3 queue 1
        local_port <= 3'h3;
        pkt_queue <= 2'h1;
        wr(ADDR_POINTER, 32'h0003_0001);
        wr(ADDR_CONTROL, 32'h0000_0103);
        pkt(1'b1, 2'h1, 2'h1, 1'b0, 11'h0, 2'h1, 1'b0, 1'b0, 1'b1);
        wr(ADDR_CONTROL, 32'h0000_0303);
        pkt(1'b1, 2'h1, 2'h1, 1'b0, 11'h0, 2'h1, 1'b0, 1'b0, 1'b0);
        wr(ADDR_CONTROL, 32'h0000_0241);
        pkt(1'b0, 2'h1, 2'h1, 1'b0, 11'h0, 2'h2, 1'b0, 1'b0, 1'b1);
        wr(ADDR_CONTROL, 32'h0000_0903);
        pkt(1'b1, 2'h1, 2'h1, 1'b0, 11'h0, 2'h1, 1'b0, 1'b0, 1'b0);
        wr(ADDR_CONTROL, 32'h0000_0D03);
        pkt(1'b1, 2'h1, 2'h1, 1'b0, LVL_HI, 2'h1, 1'b1, 1'b0, 1'b1);
        pkt_queue <= 2'h0;
        pkt(1'b1, 2'h1, 2'h1, 1'b0, LVL_HI, 2'h1, 1'b1, 1'b0, 1'b0);
        pkt_queue <= 2'h1;
        $display("test monitor done");
        // A zero burst at port 3 starves only per-port policing
        wr(ADDR_BURST, 32'h0000_0000);
        wr(ADDR_CONTROL, 32'h0000_0083);
        repeat (2 * REFILL_CYCLES) @(posedge clk_sys);
        pkt(1'b1, 2'h1, 2'h1, 1'b0, 11'h0, 2'h3, 1'b0, 1'b0, 1'b0);
        wr(ADDR_CONTROL, 32'h0000_0003);
        repeat (2 * REFILL_CYCLES) @(posedge clk_sys);
        pkt(1'b1, 2'h1, 2'h1, 1'b0, 11'h0, 2'h1, 1'b0, 1'b0, 1'b0);
        rdchk("burst p3", ADDR_BURST, 32'h0000_0000);
        wr(ADDR_POINTER, 32'h0000_0001);
        rdchk("burst p0", ADDR_BURST, 32'h1000_3000);
        apb(1'b1, ADDR_RATE, 32'hAAAA_5555, 4'h3, rd, er);
        rdchk("rate strb", ADDR_RATE, 32'h1000_5555);
        wr(ADDR_POINTER, 32'h0000_0000);
        rdchk("burst q0", ADDR_BURST, 32'h1000_3000);
        $display("test indexed entries done");
        wr(ADDR_CONTROL, 32'hFFFF_FFFF);
        rdchk("control", ADDR_CONTROL, 32'h0000_0FFF);
        wr(ADDR_POINTER, 32'hFFFF_FFFF);
        rdchk("pointer", ADDR_POINTER, 32'h0007_0003);
        wr(ADDR_PM_THRESH, 32'hFFFF_FFFF);
        rdchk("pm", ADDR_PM_THRESH, 32'h07FF_07FF);
        apb(1'b1, 12'h900, 32'h1234_5678, 4'hF, rd, er);
        chk("unmapped write err", 32'h1, {31'h0, er});
        apb(1'b0, 12'h900, 32'h0, 4'hF, rd, er);
        chk("unmapped read", 32'h0, rd);
        chk("unmapped read err", 32'h1, {31'h0, er});
        $display("test reserved bits done");
        test_done();
    end
endmodule : port_policing_wred_config_tb
`default_nettype wire

//--- include/ppw_pkg.sv
package ppw_pkg;

    // Register byte addresses
    localparam logic [11:0] ADDR_POINTER = 12'h804;
    localparam logic [11:0] ADDR_CONTROL = 12'h80C;
    localparam logic [11:0] ADDR_RATE = 12'h820;
    localparam logic [11:0] ADDR_BURST = 12'h824;
    localparam logic [11:0] ADDR_PM_THRESH = 12'h830;

    // Control register fields
    localparam int CTL_ENABLE = 0;
    localparam int CTL_BLIND = 1;
    localparam int CTL_DROP_SRP = 2;
    localparam int CTL_REMAP = 3;
    localparam int CTL_MARK = 4;
    localparam int CTL_NONIP_LO = 5;
    localparam int CTL_PORT_BASED = 7;
    localparam int CTL_MON_LO = 8;
    localparam int CTL_DROP_ALL = 10;
    localparam int CTL_DROPPED_ONLY = 11;
    localparam logic [31:0] CTL_MASK = 32'h0000_0FFF;
    localparam logic [31:0] CTL_RESET = 32'h0000_0020;

    // Pointer register fields
    localparam int PTR_PORT_LO = 16;
    localparam int PTR_QUEUE_LO = 0;
    localparam logic [31:0] PTR_MASK = 32'h0007_0003;
    localparam logic [31:0] PTR_RESET = 32'h0000_0000;

    // Indirect entries and packet-memory thresholds
    localparam logic [31:0] RATE_RESET = 32'h1000_2000;
    localparam logic [31:0] BURST_RESET = 32'h1000_3000;
    localparam logic [31:0] PM_RESET = 32'h0400_0080;
    localparam logic [31:0] PM_MASK = 32'h07FF_07FF;
    localparam int ENTRIES = 32;
    localparam int QUEUES = 4;

    // Colors and monitor selections share one 2-bit code space
    localparam logic [1:0] MON_DROPPED = 2'h0;
    localparam logic [1:0] COLOR_GREEN = 2'h1;
    localparam logic [1:0] COLOR_YELLOW = 2'h2;
    localparam logic [1:0] COLOR_RED = 2'h3;

    // Token refill interval
    localparam int CLK_PERIOD_NS = 10;
    localparam int REFILL_NS = 1000;
    localparam int REFILL_CYCLES = REFILL_NS / CLK_PERIOD_NS;
    localparam logic [15:0] REFILL_LAST = 16'(REFILL_CYCLES - 1);

endpackage : ppw_pkg
